// ### rwcp_map.vh
// register map and field constants of the wake, channel and power register slice
// assumes an spi framer outside that presents one byte access per strobe
`ifndef RWCP_MAP_VH
`define RWCP_MAP_VH
`define RWCP_ADDR_WAKE_EN 6'h1C
`define RWCP_ADDR_WAKE_ST 6'h1D
`define RWCP_ADDR_ANALOG 6'h20
`define RWCP_ADDR_CHANNEL 6'h21
`define RWCP_ADDR_STRENGTH 6'h22
`define RWCP_ADDR_BIAS 6'h23
`define RWCP_ADDR_PWR_CTL 6'h2E
`define RWCP_ADDR_CARRIER 6'h2F
`define RWCP_ADDR_ID_BASE 6'h3C
`define RWCP_ID_PAGE 4'hF
`define RWCP_RST_WAKE_EN 8'h00
`define RWCP_RST_WAKE_ST 1'b1
`define RWCP_RST_ANALOG 8'h00
`define RWCP_RST_CHANNEL 7'h00
`define RWCP_RST_STRENGTH 6'h00
`define RWCP_RST_BIAS 3'h0
`define RWCP_RST_PROT 8'h00
`define RWCP_BIT_WAKE_EN 0
`define RWCP_BIT_WR_UNLOCK 6
`define RWCP_BIT_ID_READ 5
`define RWCP_BIT_AMP_DRIVE 2
`define RWCP_BIT_AMP_POL 1
`define RWCP_BIT_SOFT_RESET 0
`define RWCP_ANALOG_KEEP 8'h66
`define RWCP_PROT_KEEP 8'h80
`define RWCP_CHANNEL_W 7
`define RWCP_STRENGTH_W 5
`define RWCP_BIAS_W 3
`define RWCP_READY_CYCLES 16
`endif

// ### rwcp_sync.v
// two-flop synchroniser for one pin level
// assumes the pin is asynchronous to clock_i
`timescale 1ns/1ps
module rwcp_sync
(
    input wire clock_i,
    input wire rst_i,
    input wire level_i,
    output wire level_o
);
    reg meta_r;
    reg sync_r;
    always @(posedge clock_i)
    begin
        if (rst_i)
        begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
        end
        else
        begin
            meta_r <= level_i;
            sync_r <= meta_r;
        end
    end
    assign level_o = sync_r;
endmodule // rwcp_sync

// ### rwcp_id_rom.v
// four-byte identifier store with registered read data
// assumes contents come from parameters set at integration
`timescale 1ns/1ps
module rwcp_id_rom
#(
    // arbitrary neutral identifier value
    parameter [31:0] ID_VALUE = 32'h00000000
)
(
    input wire clock_i,
    input wire rst_i,
    input wire [1:0] index_i,
    output reg [7:0] data_o
);
    always @(posedge clock_i)
    begin
        if (rst_i)
            data_o <= 8'h00;
        else
            data_o <= ID_VALUE[{index_i, 3'b000} +: 8];
    end
endmodule // rwcp_id_rom

// ### rwcp_regs.v
// register slice: wake interrupt, analog control, channel, strength, bias
// assumes an spi framer delivering byte accesses as one-cycle strobes on clock_i
`timescale 1ns/1ps
`include "rwcp_map.vh"
module rwcp_regs
#(
    parameter [31:0] ID_VALUE = 32'h00000000,
    parameter READY_CYCLES = `RWCP_READY_CYCLES
)
(
    input wire clock_i,
    input wire rst_i,
    input wire power_down_pin_i,
    input wire [5:0] addr_i,
    input wire wr_i,
    input wire rd_i,
    input wire [7:0] wdata_i,
    output reg [7:0] rdata_o,
    output reg rvalid_o,
    input wire rx_mode_enter_i,
    input wire [4:0] strength_sample_i,
    output wire irq_o,
    output reg amp_control_pin_o,
    output reg amp_control_pin_oe_o,
    output wire [6:0] synth_channel_o,
    output wire [2:0] amp_gain_setting_o,
    output wire id_power_o,
    output wire [7:0] pwr_ctl_o,
    output wire [7:0] carrier_ctl_o,
    output wire spi_ready_o,
    output wire soft_reset_o
);
    // =========================================================
    // reset and pin input
    // =========================================================
    reg soft_rst_r;
    wire any_rst;
    wire pd_sync;
    assign any_rst = rst_i | soft_rst_r;
    assign soft_reset_o = soft_rst_r;
    rwcp_sync u_pd_sync
    (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .level_i(power_down_pin_i),
        .level_o(pd_sync)
    );

    function sel;
        input [5:0] a;
        input [5:0] b;
        begin
            sel = (a == b);
        end
    endfunction

    // =========================================================
    // wake event: counts ready time after power-down release
    // =========================================================
    reg [7:0] ready_cnt_r;
    reg ready_r;
    reg wake_pend_r;
    reg [7:0] wake_en_r;
    wire wake_event;
    assign wake_event = ~pd_sync & ~ready_r & (ready_cnt_r == READY_CYCLES[7:0] - 8'h01);
    assign spi_ready_o = ready_r;
    always @(posedge clock_i)
    begin
        if (any_rst | pd_sync)
        begin
            ready_cnt_r <= 8'h00;
            ready_r <= 1'b0;
        end
        else if (!ready_r)
        begin
            ready_cnt_r <= ready_cnt_r + 8'h01;
            if (wake_event)
                ready_r <= 1'b1;
        end
    end

    wire rd_wake_st;
    assign rd_wake_st = rd_i & sel(addr_i, `RWCP_ADDR_WAKE_ST);
    always @(posedge clock_i)
    begin
        if (any_rst)
            wake_pend_r <= `RWCP_RST_WAKE_ST;
        else if (wake_event)
            wake_pend_r <= 1'b1;
        else if (rd_wake_st)
            wake_pend_r <= 1'b0;
    end
    assign irq_o = wake_pend_r & wake_en_r[`RWCP_BIT_WAKE_EN];

    // =========================================================
    // writable registers
    // =========================================================
    reg [7:0] analog_r;
    reg [6:0] channel_r;
    reg [2:0] bias_r;
    reg [7:0] pwr_ctl_r;
    reg [7:0] carrier_r;
    reg [5:0] strength_r;
    always @(posedge clock_i)
    begin
        if (any_rst)
        begin
            wake_en_r <= `RWCP_RST_WAKE_EN;
            analog_r <= `RWCP_RST_ANALOG;
            channel_r <= `RWCP_RST_CHANNEL;
            bias_r <= `RWCP_RST_BIAS;
            pwr_ctl_r <= `RWCP_RST_PROT;
            carrier_r <= `RWCP_RST_PROT;
        end
        else if (wr_i)
        begin
            if (sel(addr_i, `RWCP_ADDR_WAKE_EN))
                wake_en_r <= {7'h00, wdata_i[`RWCP_BIT_WAKE_EN]};
            if (sel(addr_i, `RWCP_ADDR_ANALOG))
                analog_r <= wdata_i & `RWCP_ANALOG_KEEP;
            if (sel(addr_i, `RWCP_ADDR_CHANNEL))
                channel_r <= wdata_i[`RWCP_CHANNEL_W-1:0];
            if (sel(addr_i, `RWCP_ADDR_BIAS))
                bias_r <= wdata_i[`RWCP_BIAS_W-1:0];
            if (sel(addr_i, `RWCP_ADDR_PWR_CTL) & analog_r[`RWCP_BIT_WR_UNLOCK])
                pwr_ctl_r <= wdata_i & `RWCP_PROT_KEEP;
            if (sel(addr_i, `RWCP_ADDR_CARRIER) & analog_r[`RWCP_BIT_WR_UNLOCK])
                carrier_r <= wdata_i & `RWCP_PROT_KEEP;
        end
    end

    // self-clearing: the pulse resets every register except the pin synchroniser and the id rom output, itself included
    always @(posedge clock_i)
    begin
        if (rst_i | soft_rst_r)
            soft_rst_r <= 1'b0;
        else
            soft_rst_r <= wr_i & sel(addr_i, `RWCP_ADDR_ANALOG) & wdata_i[`RWCP_BIT_SOFT_RESET];
    end

    // =========================================================
    // signal strength capture, read-only to the host
    // =========================================================
    always @(posedge clock_i)
    begin
        if (any_rst)
            strength_r <= `RWCP_RST_STRENGTH;
        else if (rx_mode_enter_i)
            strength_r <= {1'b1, strength_sample_i};
    end

    // =========================================================
    // amplifier control pin
    // =========================================================
    always @(posedge clock_i)
    begin
        if (any_rst)
        begin
            amp_control_pin_o <= 1'b0;
            amp_control_pin_oe_o <= 1'b0;
        end
        else
        begin
            amp_control_pin_oe_o <= analog_r[`RWCP_BIT_AMP_DRIVE];
            amp_control_pin_o <= analog_r[`RWCP_BIT_AMP_DRIVE] & ~analog_r[`RWCP_BIT_AMP_POL];
        end
    end

    assign synth_channel_o = channel_r;
    assign amp_gain_setting_o = bias_r;
    assign id_power_o = analog_r[`RWCP_BIT_ID_READ];
    assign pwr_ctl_o = pwr_ctl_r;
    assign carrier_ctl_o = carrier_r;

    // =========================================================
    // read path, one cycle after the strobe
    // =========================================================
    wire [7:0] id_byte;
    rwcp_id_rom #(.ID_VALUE(ID_VALUE)) u_id
    (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .index_i(addr_i[1:0]),
        .data_o(id_byte)
    );
    reg id_rd_r;
    reg [7:0] rdata_r;
    reg [7:0] rd_mux;
    always @*
    begin
        rd_mux = 8'h00;
        case (addr_i)
            `RWCP_ADDR_WAKE_EN: rd_mux = wake_en_r;
            `RWCP_ADDR_WAKE_ST: rd_mux = {7'h00, wake_pend_r};
            `RWCP_ADDR_ANALOG: rd_mux = analog_r;
            `RWCP_ADDR_CHANNEL: rd_mux = {1'b0, channel_r};
            `RWCP_ADDR_STRENGTH: rd_mux = {2'b00, strength_r};
            `RWCP_ADDR_BIAS: rd_mux = {5'h00, bias_r};
            `RWCP_ADDR_PWR_CTL: rd_mux = pwr_ctl_r;
            `RWCP_ADDR_CARRIER: rd_mux = carrier_r;
            default: rd_mux = 8'h00;
        endcase
    end
    always @(posedge clock_i)
    begin
        if (any_rst)
        begin
            rdata_r <= 8'h00;
            rvalid_o <= 1'b0;
            id_rd_r <= 1'b0;
        end
        else
        begin
            rvalid_o <= rd_i;
            rdata_r <= rd_mux;
            id_rd_r <= rd_i & (addr_i[5:2] == `RWCP_ID_PAGE) & analog_r[`RWCP_BIT_ID_READ];
        end
    end
    // identifier byte overrides the mux when gated on; rom and mux registers land in the same cycle
    always @*
    begin
        rdata_o = id_rd_r ? id_byte : rdata_r;
    end
endmodule // rwcp_regs

// ### rwcp_regs_monitor.sv
// checker for the wake, channel and power register slice
// assumes it is bound to rwcp_regs and sees its ports only
`timescale 1ns/1ps
module rwcp_regs_monitor
(
    input wire clock_i,
    input wire rst_i,
    input wire [5:0] addr_i,
    input wire wr_i,
    input wire rd_i,
    input wire [7:0] wdata_i,
    input wire irq_o,
    input wire amp_control_pin_o,
    input wire amp_control_pin_oe_o,
    input wire [6:0] synth_channel_o,
    input wire [2:0] amp_gain_setting_o,
    input wire soft_reset_o
);
    // ==========================================
    // register side effects
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);
    wire ana_wr = wr_i && addr_i == 6'h20 && !wdata_i[0];
    status_clear_a: assert property (rd_i && addr_i == 6'h1D |=> !irq_o)
        else $error("irq still set after status read");
    wake_gate_a: assert property (wr_i && addr_i == 6'h1C && !wdata_i[0] |-> ##2 !irq_o)
        else $error("irq set while wake disabled");
    amp_drive_a: assert property (ana_wr |-> ##2 amp_control_pin_oe_o == $past(wdata_i[2], 2))
        else $error("amp pin enable wrong");
    amp_polarity_a: assert property (ana_wr && wdata_i[2] |-> ##2 amp_control_pin_o == !$past(wdata_i[1], 2))
        else $error("amp pin level wrong");
    soft_pulse_a: assert property (wr_i && addr_i == 6'h20 && wdata_i[0] |=> soft_reset_o ##1 !soft_reset_o)
        else $error("soft reset pulse wrong");
    soft_defaults_a: assert property (soft_reset_o |-> ##2 (synth_channel_o == 7'h00 && amp_gain_setting_o == 3'h0
        && !amp_control_pin_oe_o && !irq_o))
        else $error("register not restored by soft reset");
    chan_write_a: assert property (wr_i && addr_i == 6'h21 |-> ##2 synth_channel_o == $past(wdata_i[6:0], 2))
        else $error("channel write lost");
    gain_write_a: assert property (wr_i && addr_i == 6'h23 |-> ##2 amp_gain_setting_o == $past(wdata_i[2:0], 2))
        else $error("bias write lost");
endmodule // rwcp_regs_monitor
bind rwcp_regs rwcp_regs_monitor u_mon (.clock_i, .rst_i, .addr_i, .wr_i, .rd_i, .wdata_i, .irq_o,
    .amp_control_pin_o, .amp_control_pin_oe_o, .synth_channel_o, .amp_gain_setting_o, .soft_reset_o);

// ### rwcp_host.sv
// host model: byte accesses as the serial framer hands them to the slice
// assumes one clock shared with the slice; drives just after rising edges
`timescale 1ns/1ps
module rwcp_host
(
    input wire clock_i,
    input wire [7:0] rdata_i,
    input wire rvalid_i,
    output logic [5:0] addr_o = 6'h00,
    output logic wr_o = 1'b0,
    output logic rd_o = 1'b0,
    output logic [7:0] wdata_o = 8'h00
);
    // ==========================================
    // access tasks; released lines show inverted values
    task automatic write(input logic [5:0] a, input logic [7:0] d);
    begin
        @(posedge clock_i);
        addr_o <= a;
        wdata_o <= d;
        wr_o <= 1'b1;
        @(posedge clock_i);
        wr_o <= 1'b0;
        addr_o <= ~a;
        wdata_o <= ~d;
    end
    endtask
    task automatic read(input logic [5:0] a, output logic [7:0] d, output logic ok);
        integer n;
    begin
        ok = 1'b0;
        d = 8'hXX;
        @(posedge clock_i);
        addr_o <= a;
        rd_o <= 1'b1;
        @(posedge clock_i);
        rd_o <= 1'b0;
        addr_o <= ~a;
        for (n = 0; n < 4 && !ok; n = n + 1)
        begin
            #1;
            if (rvalid_i === 1'b1)
            begin
                d = rdata_i;
                ok = 1'b1;
            end
            else
                @(posedge clock_i);
        end
    end
    endtask
endmodule // rwcp_host

// ### rwcp_regs_test.sv
// self-checking bench for the wake, channel and power register slice
// assumes rwcp_host as the access master and the bound checker
`timescale 1ns/1ps
module rwcp_regs_test;
    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    logic pd = 1'b1;
    logic rx = 1'b0;
    logic [4:0] smp = 5'h00;
    wire [5:0] addr;
    wire [7:0] wdata, rdata, pwr, car;
    wire [6:0] chan;
    wire [2:0] gain;
    wire wr, rd, rvalid, irq, pin, pin_oe, idp, ready;
    integer n_fail = 0;
    integer tests_run = 0;
    // identifier value is arbitrary
    rwcp_regs #(.ID_VALUE(32'hA5C3E187), .READY_CYCLES(4)) u_dut (.clock_i(clock_i), .rst_i(rst_i),
        .power_down_pin_i(pd), .addr_i(addr), .wr_i(wr), .rd_i(rd), .wdata_i(wdata), .rdata_o(rdata),
        .rvalid_o(rvalid), .rx_mode_enter_i(rx), .strength_sample_i(smp), .irq_o(irq), .amp_control_pin_o(pin),
        .amp_control_pin_oe_o(pin_oe), .synth_channel_o(chan), .amp_gain_setting_o(gain), .id_power_o(idp),
        .pwr_ctl_o(pwr), .carrier_ctl_o(car), .spi_ready_o(ready), .soft_reset_o());
    rwcp_host u_host (.clock_i(clock_i), .rdata_i(rdata), .rvalid_i(rvalid), .addr_o(addr), .wr_o(wr),
        .rd_o(rd), .wdata_o(wdata));
    // ==========================================
    // helpers
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    begin
        tests_run = tests_run + 1;
        if (seen !== exp)
        begin
            n_fail = n_fail + 1;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    end
    endtask
    task automatic give_verdict;
    begin
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    end
    endtask
    task automatic rchk(input logic [5:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic ok;
    begin
        u_host.read(a, d, ok);
        check($sformatf("reg %h", a), d, exp);
        if (ok !== 1'b1)
            give_verdict;
    end
    endtask
    task automatic settle;
    begin
        @(posedge clock_i);
        #1;
    end
    endtask
    task automatic wake_cycle;
        integer n;
    begin
        @(posedge clock_i);
        pd <= 1'b1;
        repeat (6) @(posedge clock_i);
        pd <= 1'b0;
        for (n = 0; n < 40 && ready !== 1'b1; n = n + 1)
            @(posedge clock_i);
        check("ready", {7'h00, ready}, 8'h01);
        if (ready !== 1'b1)
            give_verdict;
        repeat (3) settle;
    end
    endtask
    task automatic sample_rx(input logic [4:0] s);
    begin
        @(posedge clock_i);
        smp <= s;
        rx <= 1'b1;
        @(posedge clock_i);
        rx <= 1'b0;
        smp <= ~s;
    end
    endtask
    initial
    begin
        forever #50 clock_i = ~clock_i;
    end
    // ==========================================
    // scenarios
    initial
    begin
        repeat (8) @(posedge clock_i);
        rst_i <= 1'b0;
        wake_cycle;
        rchk(6'h1D, 8'h01);
        rchk(6'h1D, 8'h00);
        u_host.write(6'h1D, 8'h01);
        rchk(6'h1D, 8'h00);
        rchk(6'h1C, 8'h00);
        rchk(6'h20, 8'h00);
        rchk(6'h30, 8'h00);
        u_host.write(6'h1C, 8'h01);
        wake_cycle;
        check("irq wake", {7'h00, irq}, 8'h01);
        rchk(6'h1D, 8'h01);
        check("irq read", {7'h00, irq}, 8'h00);
        u_host.write(6'h1C, 8'h00);
        wake_cycle;
        check("irq masked", {7'h00, irq}, 8'h00);
        rchk(6'h1D, 8'h01);
        u_host.write(6'h2E, 8'h80);
        u_host.write(6'h20, 8'h40);
        u_host.write(6'h2F, 8'h80);
        u_host.write(6'h20, 8'h20);
        u_host.write(6'h2E, 8'h00);
        settle;
        check("pwr", pwr, 8'h00);
        check("carrier", car, 8'h80);
        check("id power", {7'h00, idp}, 8'h01);
        rchk(6'h3C, 8'h87);
        u_host.write(6'h20, 8'h04);
        rchk(6'h3F, 8'h00);
        check("amp on", {6'h00, pin_oe, pin}, 8'h03);
        u_host.write(6'h20, 8'h06);
        settle;
        check("amp low", {6'h00, pin_oe, pin}, 8'h02);
        u_host.write(6'h20, 8'h02);
        settle;
        check("amp off", {7'h00, pin_oe}, 8'h00);
        u_host.write(6'h21, 8'h4F);
        u_host.write(6'h23, 8'h07);
        settle;
        check("channel", {1'b0, chan}, 8'h4F);
        check("bias", {5'h00, gain}, 8'h07);
        u_host.write(6'h22, 8'h3F);
        rchk(6'h22, 8'h00);
        sample_rx(5'h15);
        rchk(6'h22, 8'h35);
        sample_rx(5'h0C);
        rchk(6'h22, 8'h2C);
        u_host.write(6'h20, 8'h01);
        settle;
        rchk(6'h21, 8'h00);
        rchk(6'h23, 8'h00);
        rchk(6'h1D, 8'h01);
        give_verdict;
    end
endmodule // rwcp_regs_test
